// ### core/brfd_map.svh
// Address, size and reset constants of the boot ROM and Flash decoder.
`ifndef BRFD_MAP_SVH
`define BRFD_MAP_SVH

// Local bus boot region and device windows.
`define BRFD_LOW_BASE      32'hFF800000
`define BRFD_HIGH_BASE     32'hFFA00000
`define BRFD_FLASH_SIZE    32'h00200000
`define BRFD_SOCK_256K     32'h00040000
`define BRFD_SOCK_512K     32'h00080000
`define BRFD_SOCK_1M       32'h00100000

// Printed register index of the jumper byte and its byte address.
`define BRFD_JMP_INDEX     34'h0FFF4202D
`define BRFD_JMP_ADDR      (`BRFD_JMP_INDEX * 34'h000000004)

// Block registers.
`define BRFD_CTRL_ADDR     34'h000000000
`define BRFD_STAT_ADDR     34'h000000004

// Field positions.
`define BRFD_CTRL_EN_BIT   0
`define BRFD_BOOT_BIT      4
`define BRFD_STAT_BOOT_BIT 0
`define BRFD_STAT_DENS_LSB 1

// Reset values.
`define BRFD_CTRL_RESET    1'h1
`define BRFD_JMP_RESET     8'hFF

// AXI responses.
`define BRFD_RESP_OKAY     2'h0
`define BRFD_RESP_DECERR   2'h3

`endif

// ### core/brfd_pkg.sv
// Types shared by the boot ROM and Flash decoder.
package brfd_pkg;

  typedef enum logic [1:0] {
    DENS_256K,
    DENS_512K,
    DENS_1M,
    DENS_1M_NO_FLASH
  } brfd_density_type;

endpackage

// ### core/brfd_decode.sv
// Combinational boot region decoder for socket A, socket B and Flash.
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"

module brfd_decode (
  input  wire logic [31:0]               addr_i,
  input  wire brfd_pkg::brfd_density_type density_i,
  input  wire logic                      boot_bit_i,
  output logic                           sel_a_o,
  output logic                           sel_b_o,
  output logic                           sel_flash_o
);

  function automatic logic in_win(
    input logic [31:0] a,
    input logic [31:0] base,
    input logic [31:0] size
  );
    in_win = (a >= base) && (a <= base + size - 32'h00000001);
  endfunction

  logic [31:0] sock_size;
  logic [31:0] rom_base;
  logic [31:0] flash_base;
  logic        flash_on;

  always_comb begin
    case (density_i)
      brfd_pkg::DENS_256K: sock_size = `BRFD_SOCK_256K;
      brfd_pkg::DENS_512K: sock_size = `BRFD_SOCK_512K;
      default:             sock_size = `BRFD_SOCK_1M;
    endcase
  end

  // With Flash disabled the sockets sit low whatever the boot bit.
  assign flash_on = (density_i != brfd_pkg::DENS_1M_NO_FLASH);

  // Boot bit 1 puts the sockets first, 0 puts the Flash first.
  assign rom_base   = (boot_bit_i || !flash_on) ? `BRFD_LOW_BASE
                                                : `BRFD_HIGH_BASE;
  assign flash_base = boot_bit_i ? `BRFD_HIGH_BASE : `BRFD_LOW_BASE;

  // Anything outside the active windows selects nothing.
  assign sel_a_o     = in_win(addr_i, rom_base, sock_size);
  assign sel_b_o     = in_win(addr_i, rom_base + sock_size, sock_size);
  assign sel_flash_o = flash_on &&
                       in_win(addr_i, flash_base, `BRFD_FLASH_SIZE);

endmodule

`default_nettype wire

// ### core/brfd_top.sv
// Boot ROM and Flash decoder with jumper register and AXI4-Lite slave.
// Notes on behaviour
// - Jumpers readable as one read-only byte register.
// - Jumper one on bit 0, eight on 7.
// - Fitted jumper reads 0, absent reads 1.
// - Boot bit 0 Flash first, 1 sockets first.
// - Three strapped densities, 512 KB by default.
// - Onboard Flash decodes a 2MB window.
// - Boot bit 1: Flash FFA00000 to FFBFFFFF.
// - Boot bit 0: Flash FF800000 to FF9FFFFF.
// - 256K, bit 1: sockets from FF800000.
// - 256K, bit 0: sockets from FFA00000.
// - 512K, bit 1: sockets from FF800000.
// - 512K, bit 0: sockets from FFA00000.
// - 1M, bit 1: sockets from FF800000.
// - 1M, bit 0: sockets from FFA00000.
// - Flash disabled: sockets low, never Flash.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"

module brfd_top #(
  parameter int AXI_ADDR_W = 34
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Board straps and jumpers.
  input  wire logic [1:0]            rom_density_header_i,
  input  wire logic [7:0]            jumper_fitted_i,
  // Local bus access from the processor core.
  input  wire logic                  lb_req_i,
  input  wire logic [31:0]           lb_addr_i,
  output logic                       rom_socket_a_sel_o,
  output logic                       rom_socket_b_sel_o,
  output logic                       flash_sel_o,
  // AXI4-Lite slave.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  brfd_pkg::brfd_density_type density_reg;
  logic                       strap_taken_reg;
  logic [7:0]                 jumper_state_byte_reg;
  logic                       ctrl_en_reg;
  logic                       boot_source_select_bit;

  logic                       dec_a;
  logic                       dec_b;
  logic                       dec_flash;

  logic [AXI_ADDR_W-1:0]      waddr_reg;
  logic                       waddr_ok_reg;
  logic [31:0]                wdata_reg;
  logic [3:0]                 wstrb_reg;
  logic                       wdata_ok_reg;
  logic                       bvalid_reg;
  logic [1:0]                 bresp_reg;
  logic                       rvalid_reg;
  logic [1:0]                 rresp_reg;
  logic [31:0]                rdata_reg;

  logic                       write_go;
  logic                       read_go;

  function automatic brfd_pkg::brfd_density_type strap_to_density(
    input logic [1:0] s
  );
    case (s)
      2'h0:    strap_to_density = brfd_pkg::DENS_256K;
      2'h1:    strap_to_density = brfd_pkg::DENS_512K;
      2'h2:    strap_to_density = brfd_pkg::DENS_1M;
      default: strap_to_density = brfd_pkg::DENS_1M_NO_FLASH;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
    is_mapped = (a == AXI_ADDR_W'(`BRFD_CTRL_ADDR)) ||
                (a == AXI_ADDR_W'(`BRFD_STAT_ADDR)) ||
                (a == AXI_ADDR_W'(`BRFD_JMP_ADDR));
  endfunction

  // The density straps are static, so they are caught once on the first
  // edge after reset release; until then the factory density applies.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      density_reg     <= brfd_pkg::DENS_512K;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      density_reg     <= strap_to_density(rom_density_header_i);
      strap_taken_reg <= 1'b1;
    end
  end

  // Jumpers are sampled every cycle; a fitted jumper pulls its bit low.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      jumper_state_byte_reg <= `BRFD_JMP_RESET;
    end else begin
      jumper_state_byte_reg <= ~jumper_fitted_i;
    end
  end

  assign boot_source_select_bit =
    jumper_state_byte_reg[`BRFD_BOOT_BIT];

  brfd_decode u_decode (
    .addr_i      (lb_addr_i),
    .density_i   (density_reg),
    .boot_bit_i  (boot_source_select_bit),
    .sel_a_o     (dec_a),
    .sel_b_o     (dec_b),
    .sel_flash_o (dec_flash)
  );

  // Selects are registered one cycle after the request. Clearing the
  // enable parks all three low so software can quiesce the region.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rom_socket_a_sel_o <= 1'b0;
      rom_socket_b_sel_o <= 1'b0;
      flash_sel_o        <= 1'b0;
    end else begin
      rom_socket_a_sel_o <= lb_req_i && ctrl_en_reg && dec_a;
      rom_socket_b_sel_o <= lb_req_i && ctrl_en_reg && dec_b;
      flash_sel_o        <= lb_req_i && ctrl_en_reg && dec_flash;
    end
  end

  // Write address and data are taken independently, in either order.
  assign s_axi_awready = !waddr_ok_reg && !bvalid_reg;
  assign s_axi_wready  = !wdata_ok_reg && !bvalid_reg;
  assign write_go      = waddr_ok_reg && wdata_ok_reg && !bvalid_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      waddr_reg    <= '0;
      waddr_ok_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      waddr_reg    <= s_axi_awaddr;
      waddr_ok_reg <= 1'b1;
    end else if (write_go) begin
      waddr_ok_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
      wdata_ok_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
      wdata_ok_reg <= 1'b1;
    end else if (write_go) begin
      wdata_ok_reg <= 1'b0;
    end
  end

  // Only the control register takes writes. The jumper and status
  // registers ignore them and still answer OKAY.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_en_reg <= `BRFD_CTRL_RESET;
    end else if (write_go && wstrb_reg[0] &&
                 waddr_reg == AXI_ADDR_W'(`BRFD_CTRL_ADDR)) begin
      ctrl_en_reg <= wdata_reg[`BRFD_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `BRFD_RESP_OKAY;
    end else if (write_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(waddr_reg) ? `BRFD_RESP_OKAY
                                         : `BRFD_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // One read at a time; a new address is refused while data waits.
  assign s_axi_arready = !rvalid_reg;
  assign read_go       = s_axi_arvalid && !rvalid_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `BRFD_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (read_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `BRFD_RESP_OKAY;
      if (s_axi_araddr == AXI_ADDR_W'(`BRFD_JMP_ADDR)) begin
        rdata_reg <= {24'h000000, jumper_state_byte_reg};
      end else if (s_axi_araddr == AXI_ADDR_W'(`BRFD_CTRL_ADDR)) begin
        rdata_reg <= {31'h00000000, ctrl_en_reg};
      end else if (s_axi_araddr == AXI_ADDR_W'(`BRFD_STAT_ADDR)) begin
        rdata_reg <= {29'h00000000, density_reg,
                      boot_source_select_bit};
      end else begin
        rdata_reg <= 32'h00000000;
        rresp_reg <= `BRFD_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule

`default_nettype wire

// ### dv/brfd_core_model.sv
// Processor core model issuing local bus boot region accesses.
`timescale 1ns/1ps
`default_nettype none
module brfd_core_model (
  input  wire logic        clk_i,
  output logic             lb_req_o,
  output logic [31:0]      lb_addr_o
);
  initial begin
    lb_req_o = 1'h0;
    lb_addr_o = 32'h0;
  end
  // A zero gap keeps the strobe up for a back-to-back access.
  task automatic access(input logic [31:0] a, input int gap);
    lb_req_o <= 1'h1;
    lb_addr_o <= a;
    @(posedge clk_i);
    if (gap > 0) begin
      lb_req_o <= 1'h0;
      lb_addr_o <= ~a;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ### dv/brfd_top_properties.sv
// Concurrent checks on the boot decoder ports.
`timescale 1ns/1ps
`default_nettype none
module brfd_top_properties (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  jumper_fitted_i,
  input wire logic        lb_req_i,
  input wire logic [31:0] lb_addr_i,
  input wire logic        rom_socket_a_sel_o,
  input wire logic        rom_socket_b_sel_o,
  input wire logic        flash_sel_o,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready
);
  logic [2:0] sel;
  assign sel = {rom_socket_a_sel_o, rom_socket_b_sel_o, flash_sel_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_above; lb_req_i && lb_addr_i >= 32'hFFC00000; endsequence
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  chk_idle_quiet: assert property (!lb_req_i |=> sel == 3'h0)
    else $error("select raised without a request");
  chk_one_device: assert property ($onehot0(sel))
    else $error("more than one device selected");
  chk_above_region: assert property (s_above |=> sel == 3'h0)
    else $error("select above the boot region");
  chk_below_region: assert property
    (lb_req_i && lb_addr_i < 32'hFF800000 |=> sel == 3'h0)
    else $error("select below the boot region");
  chk_flash_low: assert property
    (flash_sel_o && $past(lb_addr_i[31:21]) == 11'h7FC
     |-> $past(jumper_fitted_i[4]))
    else $error("low Flash window with wrong boot bit");
  chk_flash_high: assert property
    (flash_sel_o && $past(lb_addr_i[31:21]) == 11'h7FD
     |-> !$past(jumper_fitted_i[4]))
    else $error("high Flash window with wrong boot bit");
  chk_b_above_a: assert property
    (rom_socket_b_sel_o |-> $past(lb_addr_i) >= 32'hFF840000)
    else $error("socket B selected below its lowest base");
  chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_write_hold: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_write_refused: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response waits");
endmodule
bind brfd_top brfd_top_properties u_props (
  .clk_i(clk_i), .reset_i(reset_i), .jumper_fitted_i(jumper_fitted_i),
  .lb_req_i(lb_req_i), .lb_addr_i(lb_addr_i),
  .rom_socket_a_sel_o(rom_socket_a_sel_o),
  .rom_socket_b_sel_o(rom_socket_b_sel_o), .flash_sel_o(flash_sel_o),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready));
`default_nettype wire

// ### dv/brfd_top_tb.sv
// Self-checking bench for the boot ROM and Flash decoder.
`timescale 1ns/1ps
`default_nettype none
`include "brfd_map.svh"
module brfd_top_tb;
  logic        clk_i = 1'h0, reset_i = 1'h1, req, sa, sb, sf, req_d = 1'h0;
  logic [1:0]  dens = 2'h1, bresp, rresp;
  logic [7:0]  jf = 8'h0;
  logic [31:0] addr, wdata = 32'h0, rdata, a;
  logic [33:0] awaddr = 34'h0, araddr = 34'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awv = 1'h0, awr, wv = 1'h0, wr, bv, br = 1'h0;
  logic        arv = 1'h0, arr, rv, rr = 1'h0, en = 1'h1;
  int          error_cnt = 0, num_checks = 0, n, cd, cbt;
  logic [2:0]  sel_q[$];
  logic [33:0] ax_q[$];
  initial forever #12.5 clk_i = ~clk_i;
  brfd_core_model core (.clk_i(clk_i), .lb_req_o(req), .lb_addr_o(addr));
  brfd_top DUT (.clk_i(clk_i), .reset_i(reset_i),
    .rom_density_header_i(dens), .jumper_fitted_i(jf), .lb_req_i(req),
    .lb_addr_i(addr), .rom_socket_a_sel_o(sa), .rom_socket_b_sel_o(sb),
    .flash_sel_o(sf), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [2:0] expd(logic [31:0] x);
    logic [31:0] sz, s0, f0;
    sz = cd == 0 ? 32'h40000 : cd == 1 ? 32'h80000 : 32'h100000;
    s0 = (cbt != 0 || cd == 3) ? 32'hFF800000 : 32'hFFA00000;
    f0 = cbt != 0 ? 32'hFFA00000 : 32'hFF800000;
    if (x >= s0 && x < s0 + sz) return 3'h4;
    if (x >= s0 + sz && x < s0 + (sz << 1)) return 3'h2;
    if (cd != 3 && x >= f0 && x < f0 + 32'h200000) return 3'h1;
    return 3'h0;
  endfunction
  task automatic acc(logic [31:0] x, int g);
    sel_q.push_back(en ? expd(x) : 3'h0);
    core.access(x, g);
  endtask
  // One AXI4-Lite transfer; the master waits only on the handshakes.
  task automatic ax(bit w, logic [33:0] ad, logic [31:0] d,
                    logic [3:0] s, logic [33:0] e);
    ax_q.push_back(e);
    if (w) begin
      awaddr <= ad; wdata <= d; wstrb <= s;
      awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    end else begin
      araddr <= ad; arv <= 1'h1; rr <= 1'h1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr) wv <= 1'h0;
      if (arv && arr) arv <= 1'h0;
      if (bv && br) begin br <= 1'h0; break; end
      if (rv && rr) begin rr <= 1'h0; break; end
    end
    if (n == 50) begin error_cnt++; summarize; end
    // An idle edge between transfers gives each strobe one change per step.
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    req_d <= req;
    if ((bv && br) || (rv && rr))
      chk("axi", ax_q.pop_front(), bv ? {bresp, 32'h0} : {rresp, rdata});
  end
  always @(negedge clk_i)
    if (req_d) chk("sel", sel_q.pop_front(), {sa, sb, sf});
  initial begin
    void'($urandom(32'h13183));
    for (cd = 0; cd < 4; cd++) for (cbt = 0; cbt < 2; cbt++) begin
      reset_i <= 1'h1;
      dens <= cd[1:0];
      n = $urandom;
      jf <= {n[7:5], cbt == 0, n[3:0]};
      repeat (6) @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      // The straps are latched once, so moving them now must not show.
      dens <= ~cd[1:0];
      // Every window edge and the address just below it.
      for (int j = 0; j < 17; j++) begin
        a = 32'hFF800000 + j * 32'h40000;
        acc(a, $urandom % 3);
        acc(a - 32'h1, 1);
      end
      acc(32'hFF800000 + $urandom % 32'h400000, 1);
      ax(0, `BRFD_STAT_ADDR, 0, 0, {31'h0, cd[1:0], cbt[0]});
      ax(0, `BRFD_JMP_ADDR, 0, 0, {26'h0, ~jf});
    end
    ax(1, `BRFD_CTRL_ADDR, 0, 4'hE, 0);
    acc(32'hFF800000, 1);
    ax(1, `BRFD_CTRL_ADDR, 0, 4'h1, 0);
    en = 1'h0;
    acc(32'hFF800000, 0);
    acc(32'hFF900000, 1);
    ax(0, `BRFD_CTRL_ADDR, 0, 0, 0);
    ax(1, `BRFD_JMP_ADDR, 32'h0, 4'hF, 0);
    ax(0, `BRFD_JMP_ADDR, 0, 0, {26'h0, ~jf});
    ax(0, 34'h100, 0, 0, {`BRFD_RESP_DECERR, 32'h0});
    ax(1, 34'h100, 0, 4'hF, {`BRFD_RESP_DECERR, 32'h0});
    summarize;
  end
endmodule
`default_nettype wire
